// ### core/wdog_pkg.sv
// Constants, types and register map of the software supervision watchdog.
// Assumes a 125 MHz core clock and an APB register port with 32-bit data.
//
// Contract
// - Time-out or window type, time-out default
// - Type and period programmable only in normal
// - Init, sleep, restart start with long window; code switches it off on sleep entry and on restart entry outside a reset hold
// - New timing restarts timer at once
// - Trigger executes at chip select rising edge
// - Long open window lasts 200 ms
// - Settings one to seven select 10..1000 ms
// - Watchdog reset, count update, then long window
// - Development mode: watchdog fully off
// - Bad triggers increment saturating failure count
// - Failure count clears on listed conditions
// - Time-out: trigger anytime, restarts full period
// - Time-out expiry drives reset low
// - Window: 60 percent closed then open
// - Closed trigger or expiry drives reset low
// - Even parity over data byte, else error
// - Written reserved bit 3 joins parity
// - Guarded stop disable, error clears second arm; code keeps second arm on a parity error
// - Stop trigger or normal re-enables, clears arms
// - Restarting sequence clears set first arm
// - Bus wake restarts watchdog when enabled
package wdog_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;           // Core clock period
  localparam int MS_IN_NS = 1000000;          // One millisecond
  localparam int MS_TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
  localparam int LONG_WINDOW_MS = 200;        // Long open window time
  localparam int RESET_HOLD_MS = 10;          // Reset output low time
  localparam int CLOSED_PCT = 60;             // Closed window share
  localparam int WIN_END_PCT = 140;           // Open window end share
  localparam int PCT_FULL = 100;
  localparam int MS_W = 11;                   // Millisecond counter width

  // ****************************************************************
  // Register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_TRIGGER = 8'h00;  // supervisor_trigger_reg
  localparam logic [7:0] ADDR_WAKE = 8'h04;     // wake_control_reg_one
  localparam logic [7:0] ADDR_STATUS = 8'h08;   // Status, error clear
  localparam int TRG_CHK = 7;                   // Checksum bit
  localparam int TRG_ARM2 = 6;                  // stop_disable_arm_second
  localparam int TRG_WIN = 5;                   // window_type_select
  localparam int TRG_RSVD = 3;                  // Reserved, reads zero
  localparam int WK_BUS_EN = 0;                 // bus_wake_restart_enable
  localparam int WK_ARM1 = 1;                   // stop_disable_arm_first
  localparam int ST_SERR = 2;                   // Serial error flag
  localparam int ST_RUN = 3;                    // Watchdog running
  localparam int ST_LONG = 4;                   // Long window active
  localparam logic [2:0] PERIOD_RST = 3'h4;     // Default 100 ms
  localparam logic [1:0] CFG_TWO = 2'h1;        // Configuration 2 code
  localparam logic [1:0] FAIL_MAX_CFG2 = 2'h1;
  localparam logic [1:0] FAIL_MAX_OTHER = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_INIT = 3'h0, MODE_NORMAL = 3'h1, MODE_STOP = 3'h2,
    MODE_SLEEP = 3'h3, MODE_RESTART = 3'h4, MODE_FAILSAFE = 3'h5
  } mode_type;

  typedef enum logic [1:0] {
    WD_OFF = 2'h0, WD_LONG = 2'h1, WD_RUN = 2'h2, WD_RESET = 2'h3
  } wd_state_type;

  typedef struct packed {
    logic win;           // window_type_select
    logic [2:0] period;  // period_select_field
  } wd_cfg_type;

  // Period in milliseconds for each setting; zero falls back to 10 ms
  function automatic logic [MS_W-1:0] period_ms(input logic [2:0] sel);
    case (sel)
      3'h2: period_ms = 11'h014;
      3'h3: period_ms = 11'h032;
      3'h4: period_ms = 11'h064;
      3'h5: period_ms = 11'h0c8;
      3'h6: period_ms = 11'h1f4;
      3'h7: period_ms = 11'h3e8;
      default: period_ms = 11'h00a;
    endcase
  endfunction : period_ms

  // Share of a period in milliseconds
  function automatic logic [MS_W-1:0] pct_ms(input logic [MS_W-1:0] p, input int pct);
    int v;
    v = (int'(p) * pct) / PCT_FULL;
    pct_ms = v[MS_W-1:0];
  endfunction : pct_ms

endpackage : wdog_pkg

// ### core/sbc_window_timeout_watchdog.sv
// Software supervision watchdog with time-out and window types.
// Assumes an APB master on CORE_CLK_I, a mode controller on the same clock
// and chip select, bus wake and reset pin levels arriving asynchronously.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
module sbc_window_timeout_watchdog
  import wdog_pkg::*;
#(
  parameter int MS_TICK = MS_TICK_CYCLES  // Cycles per millisecond tick
) (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CHIP_SELECT_LOW_I,
  input wire logic BUS_WAKE_I,
  input wire logic RESET_PIN_LEVEL_I,
  input wire logic [2:0] MODE_I,
  input wire logic [1:0] CONFIG_SEL_I,
  input wire logic DEV_MODE_I,
  output logic RESET_OUTPUT_N_O,
  output logic FAILURE_COUNT_BITS_O,
  output logic NORMAL_REQ_O
);

  // ****************************************************************
  // Synchronisers and edge detection
  // ****************************************************************
  logic cs_s1_r, cs_s2_r, cs_d_r;     // Chip select pin
  logic bw_s1_r, bw_s2_r, bw_d_r;     // Bus wake pin
  logic ro_s1_r, ro_s2_r, ro_d_r;     // Reset pin level

  // Two flops per pin, then a delayed copy for edges
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      {cs_s1_r, cs_s2_r, cs_d_r} <= 3'h7;
      {bw_s1_r, bw_s2_r, bw_d_r} <= 3'h0;
      {ro_s1_r, ro_s2_r, ro_d_r} <= 3'h0;
    end else begin
      {cs_s1_r, cs_s2_r, cs_d_r} <= {CHIP_SELECT_LOW_I, cs_s1_r, cs_s2_r};
      {bw_s1_r, bw_s2_r, bw_d_r} <= {BUS_WAKE_I, bw_s1_r, bw_s2_r};
      {ro_s1_r, ro_s2_r, ro_d_r} <= {RESET_PIN_LEVEL_I, ro_s1_r, ro_s2_r};
    end
  end

  wire cs_rise = cs_s2_r && !cs_d_r;   // End of serial transfer
  wire bw_rise = bw_s2_r && !bw_d_r;   // Bus wake event
  wire ro_rise = ro_s2_r && !ro_d_r;   // Reset output released

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  mode_type mode;
  assign mode = mode_type'(MODE_I);
  mode_type mode_d_r;                  // Mode one cycle ago
  wd_state_type state_r, state_nxt;    // Watchdog phase
  wd_cfg_type cfg_r, cfg_nxt;          // Type and period
  logic [1:0] fail_cnt_r, fail_cnt_nxt;  // failure_count_bits
  logic arm1_r, arm1_nxt;              // stop_disable_arm_first
  logic arm2_r, arm2_nxt;              // stop_disable_arm_second
  logic bus_en_r, bus_en_nxt;          // bus_wake_restart_enable
  logic serr_r, serr_nxt;              // Serial error flag
  logic pend_r, pend_nxt;              // Trigger write awaits chip select
  logic [7:0] trig_byte_r, trig_byte_nxt;  // Written data byte
  logic cause_wd_r, cause_wd_nxt;      // Last reset came from watchdog
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] presc_r;                // Millisecond prescaler
  logic [MS_W-1:0] ms_r;               // Elapsed milliseconds
  logic restart_tmr;                   // Restart both counters
  logic failure_count_bits_r, normal_req_r;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire setup = PSEL_I && !PENABLE_I;
  wire access = PSEL_I && PENABLE_I;
  wire hit_trig = (PADDR_I == ADDR_TRIGGER);
  wire hit_wake = (PADDR_I == ADDR_WAKE);
  wire hit_stat = (PADDR_I == ADDR_STATUS);
  wire mapped = hit_trig || hit_wake || hit_stat;
  wire wr_trig = access && PWRITE_I && hit_trig;
  wire wr_wake = access && PWRITE_I && hit_wake;
  wire wr_stat = access && PWRITE_I && hit_stat;
  wire in_normal = (mode == MODE_NORMAL);
  wire in_stop = (mode == MODE_STOP);
  wire mode_chg = (mode != mode_d_r);

  // ****************************************************************
  // Timing limits
  // ****************************************************************
  wire [MS_W-1:0] per_ms = period_ms(cfg_r.period);
  wire [MS_W-1:0] closed_ms = pct_ms(per_ms, CLOSED_PCT);
  wire [MS_W-1:0] win_end_ms = pct_ms(per_ms, WIN_END_PCT);
  wire [MS_W-1:0] run_lim = cfg_r.win ? win_end_ms : per_ms;
  wire [MS_W-1:0] long_lim = MS_W'(LONG_WINDOW_MS);
  wire [MS_W-1:0] hold_lim = MS_W'(RESET_HOLD_MS);
  wire [1:0] fail_max = (CONFIG_SEL_I == CFG_TWO) ? FAIL_MAX_CFG2 : FAIL_MAX_OTHER;

  // Trigger fires when the transfer closes
  wire trig_fire = pend_r && cs_rise;
  wire parity_ok = ~^trig_byte_r;
  wire good_fire = trig_fire && parity_ok;
  wire in_closed = cfg_r.win && (ms_r < closed_ms);
  wire long_exp = (state_r == WD_LONG) && (ms_r >= long_lim);
  wire run_exp = (state_r == WD_RUN) && (ms_r >= run_lim);
  wire hold_done = (state_r == WD_RESET) && (ms_r >= hold_lim);
  wire active = (state_r == WD_LONG) || (state_r == WD_RUN);
  wire bad_trig = good_fire && (state_r == WD_RUN) && in_closed;
  wire fail_evt = !DEV_MODE_I && (long_exp || run_exp || bad_trig);
  wire ms_tick = (presc_r == 32'(MS_TICK - 1));

  // ****************************************************************
  // Millisecond timebase
  // ****************************************************************
  // Prescaler and elapsed counter, restarted together
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      presc_r <= 32'h0;
      ms_r <= '0;
    end else if (restart_tmr) begin
      presc_r <= 32'h0;
      ms_r <= '0;
    end else begin
      presc_r <= ms_tick ? 32'h0 : presc_r + 32'h1;
      if (ms_tick && (ms_r != {MS_W{1'b1}})) begin
        ms_r <= ms_r + MS_W'(1);
      end
    end
  end

  // ****************************************************************
  // Watchdog next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    fail_cnt_nxt = fail_cnt_r;
    arm1_nxt = arm1_r;
    arm2_nxt = arm2_r;
    bus_en_nxt = bus_en_r;
    cause_wd_nxt = cause_wd_r;
    restart_tmr = 1'b0;
    pend_nxt = pend_r;
    trig_byte_nxt = trig_byte_r;
    // Latch trigger write, consumed at chip select release
    if (wr_trig) begin
      pend_nxt = 1'b1;
      trig_byte_nxt = PWDATA_I[7:0];
    end else if (cs_rise) begin
      pend_nxt = 1'b0;
    end
    // Wake register only writable in normal mode
    if (wr_wake && in_normal) begin
      bus_en_nxt = PWDATA_I[WK_BUS_EN];
      // Starting again with first arm set drops it
      arm1_nxt = arm1_r ? 1'b0 : PWDATA_I[WK_ARM1];
    end
    if (DEV_MODE_I) begin
      // Development mode keeps the watchdog silent
      state_nxt = WD_OFF;
    end else if (state_r == WD_RESET) begin
      // Hold reset low, then long window and normal request
      if (hold_done) begin
        state_nxt = WD_LONG;
        restart_tmr = 1'b1;
      end
    end else if (fail_evt) begin
      // Failure: count, reset low, mode controller told
      state_nxt = WD_RESET;
      restart_tmr = 1'b1;
      cause_wd_nxt = 1'b1;
      if (fail_cnt_r < fail_max) begin
        fail_cnt_nxt = fail_cnt_r + 2'h1;
      end
    end else if (mode_chg) begin
      restart_tmr = 1'b1;
      case (mode)
        MODE_NORMAL: begin
          // Entry to normal opens the long window unless reset hold, failure or development mode wins
          state_nxt = WD_LONG;
          arm1_nxt = 1'b0;
          arm2_nxt = 1'b0;
          cause_wd_nxt = 1'b0;
        end
        MODE_STOP: begin
          if (arm1_r && arm2_r) begin
            state_nxt = WD_OFF;
            fail_cnt_nxt = 2'h0;
          end
        end
        MODE_SLEEP: begin
          state_nxt = WD_OFF;
          fail_cnt_nxt = 2'h0;
        end
        MODE_FAILSAFE: begin
          state_nxt = WD_OFF;
          if (!cause_wd_r) begin
            fail_cnt_nxt = 2'h0;
          end
        end
        default: begin
          state_nxt = WD_OFF;
        end
      endcase
    end else if (mode == MODE_INIT && ro_rise) begin
      // Init starts once reset output releases
      state_nxt = WD_LONG;
      restart_tmr = 1'b1;
    end else if (in_stop && state_r == WD_OFF && (good_fire || (bw_rise && bus_en_r))) begin
      // Stop mode re-enable by trigger or bus wake
      state_nxt = WD_LONG;
      restart_tmr = 1'b1;
      arm1_nxt = 1'b0;
      arm2_nxt = 1'b0;
    end else if (good_fire && active && (in_normal || in_stop)) begin
      // Accepted trigger: clear count and start a fresh period
      state_nxt = WD_RUN;
      restart_tmr = 1'b1;
      fail_cnt_nxt = 2'h0;
      if (in_normal) begin
        cfg_nxt.win = trig_byte_r[TRG_WIN];
        cfg_nxt.period = trig_byte_r[2:0];
        // Second arm only with first arm set
        arm2_nxt = trig_byte_r[TRG_ARM2] && arm1_r;
      end
    end
  end

  // ****************************************************************
  // Serial error flag and read data
  // ****************************************************************
  always_comb begin
    serr_nxt = serr_r;
    if (wr_stat && PWDATA_I[ST_SERR]) begin
      serr_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (trig_fire && !parity_ok) begin
      serr_nxt = 1'b1;
    end
    prdata_nxt = prdata_r;
    if (setup && !PWRITE_I) begin
      if (hit_trig) begin
        prdata_nxt = {24'h0, 1'b0, arm2_r, cfg_r.win, 2'h0, cfg_r.period};
      end else if (hit_wake) begin
        prdata_nxt = {30'h0, arm1_r, bus_en_r};
      end else if (hit_stat) begin
        prdata_nxt = {27'h0, state_r == WD_LONG, state_r == WD_RUN, serr_r, fail_cnt_r};
      end else begin
        prdata_nxt = 32'h0;
      end
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r <= WD_OFF;
      mode_d_r <= MODE_INIT;
      cfg_r <= '{win: 1'b0, period: PERIOD_RST};
      fail_cnt_r <= 2'h0;
      arm1_r <= 1'b0;
      arm2_r <= 1'b0;
      bus_en_r <= 1'b1;
      serr_r <= 1'b0;
      pend_r <= 1'b0;
      trig_byte_r <= 8'h0;
      cause_wd_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      mode_d_r <= mode;
      cfg_r <= cfg_nxt;
      fail_cnt_r <= fail_cnt_nxt;
      arm1_r <= arm1_nxt;
      arm2_r <= arm2_nxt;
      bus_en_r <= bus_en_nxt;
      serr_r <= serr_nxt;
      pend_r <= pend_nxt;
      trig_byte_r <= trig_byte_nxt;
      cause_wd_r <= cause_wd_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Event pulses to the mode controller
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      failure_count_bits_r <= 1'b0;
      normal_req_r <= 1'b0;
    end else begin
      failure_count_bits_r <= fail_evt && (state_r != WD_RESET);
      normal_req_r <= hold_done && !DEV_MODE_I;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && !mapped;
  assign RESET_OUTPUT_N_O = (state_r != WD_RESET);
  assign FAILURE_COUNT_BITS_O = failure_count_bits_r;
  assign NORMAL_REQ_O = normal_req_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  a_parity_error: assert property (trig_fire && !parity_ok |=> serr_r)
    else $error("parity error flag not set");
  a_parity_ignore: assert property (trig_fire && !parity_ok && !fail_evt && !mode_chg
    |=> $stable(cfg_r))
    else $error("bad parity changed configuration");
  a_fail_reset_low: assert property (fail_evt && state_r != WD_RESET
    |=> !RESET_OUTPUT_N_O && FAILURE_COUNT_BITS_O)
    else $error("failure did not drive reset low");
  a_dev_silent: assert property (DEV_MODE_I |=> !FAILURE_COUNT_BITS_O ##1 !FAILURE_COUNT_BITS_O)
    else $error("watchdog failure in development mode");
  a_count_limit: assert property (fail_cnt_r <= FAIL_MAX_OTHER)
    else $error("failure count beyond saturation");
  a_good_clear: assert property (good_fire && state_r == WD_RUN && !in_closed
    && !DEV_MODE_I && !mode_chg && in_normal |=> fail_cnt_r == 2'h0)
    else $error("count not cleared by good trigger");
  a_release_long: assert property (hold_done && !DEV_MODE_I
    |=> state_r == WD_LONG && ms_r == '0 && NORMAL_REQ_O)
    else $error("no long window after reset release");
  a_stop_config: assert property (in_stop && $past(in_stop) |-> $stable(cfg_r))
    else $error("configuration changed in stop mode");
  a_arm1_restart: assert property (wr_wake && in_normal && arm1_r |=> !arm1_r)
    else $error("first arm not cleared on restart");

  c_window_trigger: cover property (good_fire && state_r == WD_RUN && cfg_r.win);
  c_closed_fail: cover property (bad_trig ##[1:20] hold_done);
  c_stop_off: cover property (in_stop && state_r == WD_OFF ##[1:50] state_r == WD_LONG);

endmodule : sbc_window_timeout_watchdog

// ### tb/host_link_model.sv
// Host side of the serial link: frames each trigger with chip select.
// Assumes the bench raises REQ_I and lowers it once chip select is low.
`timescale 1ns/10ps
module host_link_model (
  input wire logic REQ_I,
  output logic CS_N_O
);
  // ****************
  // Link clock
  // ****************
  logic lclk; // Own link clock, phase unrelated to core
  initial begin
    lclk = 1'b0;
    CS_N_O = 1'b1;
    #3;
    forever #80 lclk = ~lclk;
  end
  // Frame: one link period low, rising edge ends the transfer
  always @(posedge lclk) begin
    if (!CS_N_O) begin
      CS_N_O <= 1'b1;
    end else if (REQ_I) begin
      CS_N_O <= 1'b0;
    end
  end
endmodule : host_link_model

// ### tb/sbc_window_timeout_watchdog_test.sv
// Self-checking bench: APB master, mode controller and host link.
// Assumes a shortened millisecond tick of 10 cycles.
`timescale 1ns/10ps
module sbc_window_timeout_watchdog_test;
  import wdog_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clk, nrst, psel, pen, pwr, req, cs_n, dev, pin, bw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rst_n, wfail, nreq, err;
  logic [2:0] mode;
  int fails, tests_run, cyc, nfail, fail_cyc, k;
  sbc_window_timeout_watchdog #(.MS_TICK(10)) i_dut (
    .CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CHIP_SELECT_LOW_I(cs_n),
    .BUS_WAKE_I(bw), .RESET_PIN_LEVEL_I(pin), .MODE_I(mode),
    .CONFIG_SEL_I(2'h0), .DEV_MODE_I(dev), .RESET_OUTPUT_N_O(rst_n),
    .FAILURE_COUNT_BITS_O(wfail), .NORMAL_REQ_O(nreq)
  );
  host_link_model i_host (.REQ_I(req), .CS_N_O(cs_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cycle count, hang guard and failure pulse monitor, sampled mid-cycle
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (wfail === 1'b1) begin
      nfail <= nfail + 1;
      fail_cyc <= cyc;
    end
    if (cyc > 30000) begin
      fails++;
      end_of_test();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
  endtask : tick
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle edge so a following transfer never re-raises psel in this step
    @(posedge clk);
  endtask : apb
  // Trigger byte write, then a chip select frame, then sync and execute
  task automatic trig(input logic [7:0] b);
    int n;
    n = 0;
    apb(1'b1, ADDR_TRIGGER, {24'h0, b});
    req <= 1'b1;
    while (cs_n !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    req <= 1'b0;
    while (cs_n !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    repeat (6) tick();
  endtask : trig
  task automatic wait_fail(input int lo, input int hi);
    int n, s, o;
    n = 0;
    s = cyc;
    o = nfail;
    while (nfail == o && n < hi + 5) begin
      tick();
      n++;
    end
    chk("fail_time", 32'(fail_cyc - s >= lo && fail_cyc - s <= hi), 32'h1);
    chk("reset_low", {31'h0, rst_n}, 32'h0);
  endtask : wait_fail
  // Mode controller: restart until reset hold ends, then normal
  task automatic recover();
    int n;
    n = 0;
    mode <= MODE_RESTART;
    // Pulse sampled mid-cycle, away from the edge that launches it
    while (nreq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    tick();
    mode <= MODE_NORMAL;
    repeat (4) tick();
    chk("reset_high", {31'h0, rst_n}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("long_after_rst", rd & 32'h10, 32'h10);
  endtask : recover
  // ****************
  // Main sequence
  // ****************
  initial begin
    {psel, pen, pwr, req, dev, pin, bw} = '0;
    {paddr, pwdata, fails, tests_run, cyc, nfail, fail_cyc} = '0;
    mode = MODE_INIT;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    tick();
    // Reset values and unmapped address
    apb(1'b0, ADDR_TRIGGER, 32'h0);
    chk("trig_rst", rd, 32'h4);
    apb(1'b0, ADDR_WAKE, 32'h0);
    chk("wake_rst", rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Reset pin release in init mode starts the long window
    pin <= 1'b1;
    repeat (6) tick();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("init_long", rd & 32'h10, 32'h10);
    mode <= MODE_NORMAL;
    repeat (4) tick();
    // Time-out type, 10 ms, served three times back to back
    trig(8'h81);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("run_new", rd & 32'h1f, 32'h08);
    for (k = 0; k < 3; k++) begin
      repeat (30) tick();
      trig(8'h81);
    end
    chk("served", 32'(nfail), 32'h0);
    wait_fail(80, 125);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("count_one", rd & 32'h3, 32'h1);
    recover();
    // Odd parity via reserved bit 3 is refused
    trig(8'h89);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("par_bad", rd & 32'h7, 32'h5);
    apb(1'b1, ADDR_STATUS, 32'h4);
    trig(8'h09);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("par_ok", rd & 32'h7, 32'h0);
    apb(1'b0, ADDR_TRIGGER, 32'h0);
    chk("rsvd_zero", rd, 32'h1);
    // Window type 20 ms, third trigger lands in the closed window
    trig(8'h22);
    k = nfail;
    // Host serves inside the safe area of the 20 ms window
    repeat (150) tick();
    trig(8'h22);
    chk("open_ok", 32'(nfail - k), 32'h0);
    trig(8'h22);
    chk("closed_hit", 32'(nfail - k), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("count_cl", rd & 32'h3, 32'h1);
    // Unserved long windows saturate the count at two
    for (k = 0; k < 2; k++) begin
      recover();
      wait_fail(1980, 2030);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("count_sat", rd & 32'h3, 32'h2);
    end
    // Stop disable sequence, then bus wake restarts the watchdog
    recover();
    apb(1'b1, ADDR_WAKE, 32'h3);
    apb(1'b1, ADDR_WAKE, 32'h3);
    apb(1'b0, ADDR_WAKE, 32'h0);
    chk("arm1_restart", rd, 32'h1);
    apb(1'b1, ADDR_WAKE, 32'h3);
    trig(8'h41);
    apb(1'b0, ADDR_TRIGGER, 32'h0);
    chk("arm2_set", rd, 32'h41);
    mode <= MODE_STOP;
    repeat (4) tick();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("stop_off", rd & 32'h1f, 32'h0);
    apb(1'b1, ADDR_WAKE, 32'h0);
    bw <= 1'b1;
    repeat (6) tick();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("wake_long", rd & 32'h10, 32'h10);
    apb(1'b0, ADDR_WAKE, 32'h0);
    chk("arms_clear", rd, 32'h1);
    bw <= 1'b0;
    mode <= MODE_NORMAL;
    repeat (4) tick();
    // Development mode: no failure at all
    recover();
    dev <= 1'b1;
    k = nfail;
    repeat (2300) tick();
    chk("dev_off", {31'(nfail - k), rst_n}, 32'h1);
    end_of_test();
  end
endmodule : sbc_window_timeout_watchdog_test
